// file: b3cfg_pkg.sv
/*
 Constants, types and helper functions for the third buck regulator
 configuration bank (channels A and B, independent or single phase).
 Assumes an 8-bit register access port behind the serial control interface.
*/
// Overview of operation
// - Channel A standby register holds writable level code in bits 5:0.
// - Channel A standby bit 6 reads back the channel A range bit.
// - Channel A sleep register holds writable level code in bits 5:0.
// - Channel A sleep bit 6 reads back the channel A range bit.
// - Channel A mode register holds writable 4-bit switching mode in bits 3:0.
// - Mode bit 5 selects sleep behaviour: 0 output off, 1 pulse-frequency mode.
// - Config bit 0 picks current limit, 0 high, 1 low; bit 1 spare writable.
// - Config bits 3:2 select switching frequency, reset zero.
// - Config bits 5:4 select phase clock, reset zero.
// - Config bits 7:6 select voltage scaling step speed, reset zero.
// - Channel B normal register holds writable level code in bits 5:0.
// - Channel B normal bit 6 is read-only, set only by configuration load.
// - Channel B standby register holds writable level code in bits 5:0.
// - Channel B standby bit 6 reads back the channel B range bit.
// - Channel B sleep register holds writable level code in bits 5:0.
// - Channel B sleep bit 6 reads back the channel B range bit.
// - Channel A normal register holds writable level plus read-only range bit.
package b3cfg_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CHA_NORMAL = 8'h3c;
    localparam logic [7:0] ADDR_CHA_STANDBY = 8'h3d;
    localparam logic [7:0] ADDR_CHA_SLEEP = 8'h3e;
    localparam logic [7:0] ADDR_CHA_MODE = 8'h3f;
    localparam logic [7:0] ADDR_CHA_CONFIG = 8'h40;
    localparam logic [7:0] ADDR_CHB_NORMAL = 8'h43;
    localparam logic [7:0] ADDR_CHB_STANDBY = 8'h44;
    localparam logic [7:0] ADDR_CHB_SLEEP = 8'h45;

    // Field positions
    localparam int LEVEL_MSB = 5;
    localparam int RANGE_BIT = 6;
    localparam int MODE_MSB = 3;
    localparam int SLEEP_BEH_BIT = 5;
    localparam int ILIM_BIT = 0;
    localparam int SPARE_BIT = 1;
    localparam int FREQ_LSB = 2;
    localparam int PHASE_LSB = 4;
    localparam int SPEED_LSB = 6;

    // Reset values
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h80;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic RANGE_RST = 1'b0;

    // Power state codes on the pwr_state input
    localparam logic [1:0] PS_CODE_NORMAL = 2'h0;
    localparam logic [1:0] PS_CODE_STANDBY = 2'h1;
    localparam logic [1:0] PS_CODE_SLEEP = 2'h2;

    typedef enum logic [1:0] {
        PS_NORMAL,
        PS_STANDBY,
        PS_SLEEP
    } b3cfg_pstate_t;

    // Unknown codes fall back to normal so a glitch never drops the rail
    function automatic b3cfg_pstate_t b3cfg_decode_ps(input logic [1:0] code);
        case (code)
            PS_CODE_STANDBY: b3cfg_decode_ps = PS_STANDBY;
            PS_CODE_SLEEP: b3cfg_decode_ps = PS_SLEEP;
            default: b3cfg_decode_ps = PS_NORMAL;
        endcase
    endfunction : b3cfg_decode_ps

    // Read image of a set-point register; bit 7 is always zero
    function automatic logic [7:0] b3cfg_level_byte(input logic rng, input logic [5:0] lvl);
        b3cfg_level_byte = {1'b0, rng, lvl};
    endfunction : b3cfg_level_byte

endpackage : b3cfg_pkg

// file: b3cfg_level_sel.sv
/*
 Per-channel set-point selector: picks the normal, standby or sleep level
 for the current power state and registers it.
 Assumes the power state is already decoded and synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module b3cfg_level_sel
    import b3cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Selection inputs
    input wire b3cfg_pstate_t pstate,
    input wire logic [5:0] lvl_normal,
    input wire logic [5:0] lvl_standby,
    input wire logic [5:0] lvl_sleep,
    // Applied set-point
    output logic [5:0] lvl_out,
    output logic lvl_upd
);

    logic [5:0] lvl_d;

    always_comb begin
        case (pstate)
            PS_STANDBY: lvl_d = lvl_standby;
            PS_SLEEP: lvl_d = lvl_sleep;
            default: lvl_d = lvl_normal;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lvl_out <= LEVEL_RST[5:0];
            lvl_upd <= 1'b0;
        end else begin
            lvl_out <= lvl_d;
            lvl_upd <= (lvl_d != lvl_out);
        end
    end

endmodule : b3cfg_level_sel
`default_nettype wire

// file: b3cfg_regs.sv
/*
 Configuration register bank for the third buck regulator pair: set-point,
 mode and configuration registers, range bits from configuration load, and
 the applied set-points for each channel by power state.
 Assumes a byte-wide register access port driven by the serial control
 interface, with all inputs synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module b3cfg_regs
    import b3cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic reg_addr_miss,
    // Configuration load from one-time or trial configuration
    input wire logic cfg_load,
    input wire logic cfg_range_a,
    input wire logic cfg_range_b,
    // Operating context
    input wire logic [1:0] pwr_state,
    input wire logic single_phase,
    // Channel A applied controls
    output logic [5:0] chan_a_level_out,
    output logic chan_a_range_out,
    output logic chan_a_level_upd,
    output logic [3:0] chan_a_switch_mode,
    output logic chan_a_sleep_off,
    output logic chan_a_sleep_pfm,
    output logic chan_a_current_limit_sel,
    output logic [1:0] chan_a_freq_sel,
    output logic [1:0] chan_a_phase_sel,
    output logic [1:0] chan_a_scaling_speed,
    // Channel B applied set-point
    output logic [5:0] chan_b_level_out,
    output logic chan_b_range_out,
    output logic chan_b_level_upd
);

    // Stored fields
    logic [5:0] chan_a_normal_level_q;
    logic [5:0] chan_a_standby_level_q;
    logic [5:0] chan_a_sleep_level_q;
    logic [3:0] chan_a_switch_mode_q;
    logic chan_a_sleep_behaviour_q;
    logic chan_a_current_limit_sel_q;
    logic chan_a_spare_q;
    logic [1:0] chan_a_freq_sel_q;
    logic [1:0] chan_a_phase_sel_q;
    logic [1:0] chan_a_scaling_speed_q;
    logic [5:0] chan_b_normal_level_q;
    logic [5:0] chan_b_standby_level_q;
    logic [5:0] chan_b_sleep_level_q;
    logic chan_a_range_q;
    logic chan_b_range_q;

    // Write decode
    logic wr_cha_normal;
    logic wr_cha_standby;
    logic wr_cha_sleep;
    logic wr_cha_mode;
    logic wr_cha_config;
    logic wr_chb_normal;
    logic wr_chb_standby;
    logic wr_chb_sleep;

    // Read path
    logic [7:0] rd_data_d;
    logic rd_miss_d;

    // Power state handling
    b3cfg_pstate_t pstate;
    logic [5:0] b_sel_normal;
    logic [5:0] b_sel_standby;
    logic [5:0] b_sel_sleep;
    logic [5:0] b_lvl;
    logic b_upd;

    // Strobe and address go in as arguments so each assign sees every operand change
    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] target);
        wr_hit = en && (a == target);
    endfunction : wr_hit

    assign wr_cha_normal = wr_hit(reg_wr_en, reg_addr, ADDR_CHA_NORMAL);
    assign wr_cha_standby = wr_hit(reg_wr_en, reg_addr, ADDR_CHA_STANDBY);
    assign wr_cha_sleep = wr_hit(reg_wr_en, reg_addr, ADDR_CHA_SLEEP);
    assign wr_cha_mode = wr_hit(reg_wr_en, reg_addr, ADDR_CHA_MODE);
    assign wr_cha_config = wr_hit(reg_wr_en, reg_addr, ADDR_CHA_CONFIG);
    assign wr_chb_normal = wr_hit(reg_wr_en, reg_addr, ADDR_CHB_NORMAL);
    assign wr_chb_standby = wr_hit(reg_wr_en, reg_addr, ADDR_CHB_STANDBY);
    assign wr_chb_sleep = wr_hit(reg_wr_en, reg_addr, ADDR_CHB_SLEEP);

    // Channel A set-points
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_normal_level_q <= LEVEL_RST[5:0];
        end else if (wr_cha_normal) begin
            chan_a_normal_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_standby_level_q <= LEVEL_RST[5:0];
        end else if (wr_cha_standby) begin
            chan_a_standby_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_sleep_level_q <= LEVEL_RST[5:0];
        end else if (wr_cha_sleep) begin
            chan_a_sleep_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    // Channel A mode; bit 4 and bits 7:6 are not stored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_switch_mode_q <= MODE_RST[MODE_MSB:0];
        end else if (wr_cha_mode) begin
            chan_a_switch_mode_q <= reg_wr_data[MODE_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_sleep_behaviour_q <= MODE_RST[SLEEP_BEH_BIT];
        end else if (wr_cha_mode) begin
            chan_a_sleep_behaviour_q <= reg_wr_data[SLEEP_BEH_BIT];
        end
    end

    // Channel A configuration; every bit is writable, the spare included
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_current_limit_sel_q <= CONFIG_RST[ILIM_BIT];
        end else if (wr_cha_config) begin
            chan_a_current_limit_sel_q <= reg_wr_data[ILIM_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_spare_q <= CONFIG_RST[SPARE_BIT];
        end else if (wr_cha_config) begin
            chan_a_spare_q <= reg_wr_data[SPARE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_freq_sel_q <= CONFIG_RST[FREQ_LSB +: 2];
        end else if (wr_cha_config) begin
            chan_a_freq_sel_q <= reg_wr_data[FREQ_LSB +: 2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_phase_sel_q <= CONFIG_RST[PHASE_LSB +: 2];
        end else if (wr_cha_config) begin
            chan_a_phase_sel_q <= reg_wr_data[PHASE_LSB +: 2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_scaling_speed_q <= CONFIG_RST[SPEED_LSB +: 2];
        end else if (wr_cha_config) begin
            chan_a_scaling_speed_q <= reg_wr_data[SPEED_LSB +: 2];
        end
    end

    // Channel B set-points
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_b_normal_level_q <= LEVEL_RST[5:0];
        end else if (wr_chb_normal) begin
            chan_b_normal_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_b_standby_level_q <= LEVEL_RST[5:0];
        end else if (wr_chb_standby) begin
            chan_b_standby_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_b_sleep_level_q <= LEVEL_RST[5:0];
        end else if (wr_chb_sleep) begin
            chan_b_sleep_level_q <= reg_wr_data[LEVEL_MSB:0];
        end
    end

    // Range bits come only from a configuration load, never from a bus write.
    // They are captured by a clocked load so reset only ever forces a constant.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_range_q <= RANGE_RST;
            chan_b_range_q <= RANGE_RST;
        end else if (cfg_load) begin
            chan_a_range_q <= cfg_range_a;
            chan_b_range_q <= cfg_range_b;
        end
    end

    // Read multiplexer; set-point registers share one range bit per channel
    always_comb begin
        rd_data_d = 8'h00;
        rd_miss_d = 1'b0;
        case (reg_addr)
            ADDR_CHA_NORMAL: begin
                rd_data_d = b3cfg_level_byte(chan_a_range_q, chan_a_normal_level_q);
            end
            ADDR_CHA_STANDBY: begin
                rd_data_d = b3cfg_level_byte(chan_a_range_q, chan_a_standby_level_q);
            end
            ADDR_CHA_SLEEP: begin
                rd_data_d = b3cfg_level_byte(chan_a_range_q, chan_a_sleep_level_q);
            end
            ADDR_CHA_MODE: begin
                rd_data_d = {2'b00, chan_a_sleep_behaviour_q, 1'b0, chan_a_switch_mode_q};
            end
            ADDR_CHA_CONFIG: begin
                rd_data_d = {chan_a_scaling_speed_q, chan_a_phase_sel_q, chan_a_freq_sel_q,
                    chan_a_spare_q, chan_a_current_limit_sel_q};
            end
            ADDR_CHB_NORMAL: begin
                rd_data_d = b3cfg_level_byte(chan_b_range_q, chan_b_normal_level_q);
            end
            ADDR_CHB_STANDBY: begin
                rd_data_d = b3cfg_level_byte(chan_b_range_q, chan_b_standby_level_q);
            end
            ADDR_CHB_SLEEP: begin
                rd_data_d = b3cfg_level_byte(chan_b_range_q, chan_b_sleep_level_q);
            end
            default: begin
                rd_data_d = 8'h00;
                rd_miss_d = 1'b1;
            end
        endcase
    end

    // Read answer one cycle after the strobe; data holds until the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_data_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rd_valid <= 1'b0;
            reg_addr_miss <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            reg_addr_miss <= reg_rd_en && rd_miss_d;
        end
    end

    // Power state
    assign pstate = b3cfg_decode_ps(pwr_state);

    // In single phase both halves run off the channel A set-points
    assign b_sel_normal = single_phase ? chan_a_normal_level_q : chan_b_normal_level_q;
    assign b_sel_standby = single_phase ? chan_a_standby_level_q : chan_b_standby_level_q;
    assign b_sel_sleep = single_phase ? chan_a_sleep_level_q : chan_b_sleep_level_q;

    b3cfg_level_sel u_sel_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .pstate(pstate),
        .lvl_normal(chan_a_normal_level_q),
        .lvl_standby(chan_a_standby_level_q),
        .lvl_sleep(chan_a_sleep_level_q),
        .lvl_out(chan_a_level_out),
        .lvl_upd(chan_a_level_upd)
    );

    b3cfg_level_sel u_sel_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .pstate(pstate),
        .lvl_normal(b_sel_normal),
        .lvl_standby(b_sel_standby),
        .lvl_sleep(b_sel_sleep),
        .lvl_out(b_lvl),
        .lvl_upd(b_upd)
    );

    assign chan_b_level_out = b_lvl;
    assign chan_b_level_upd = b_upd;

    // Applied range and switching controls, registered alongside the level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_range_out <= RANGE_RST;
            chan_b_range_out <= RANGE_RST;
        end else begin
            chan_a_range_out <= chan_a_range_q;
            chan_b_range_out <= single_phase ? chan_a_range_q : chan_b_range_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_switch_mode <= MODE_RST[MODE_MSB:0];
            chan_a_current_limit_sel <= CONFIG_RST[ILIM_BIT];
            chan_a_freq_sel <= CONFIG_RST[FREQ_LSB +: 2];
            chan_a_phase_sel <= CONFIG_RST[PHASE_LSB +: 2];
            chan_a_scaling_speed <= CONFIG_RST[SPEED_LSB +: 2];
        end else begin
            chan_a_switch_mode <= chan_a_switch_mode_q;
            chan_a_current_limit_sel <= chan_a_current_limit_sel_q;
            chan_a_freq_sel <= chan_a_freq_sel_q;
            chan_a_phase_sel <= chan_a_phase_sel_q;
            chan_a_scaling_speed <= chan_a_scaling_speed_q;
        end
    end

    // Sleep behaviour only matters while asleep; both flags stay low otherwise
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan_a_sleep_off <= 1'b0;
            chan_a_sleep_pfm <= 1'b0;
        end else begin
            chan_a_sleep_off <= (pstate == PS_SLEEP) && !chan_a_sleep_behaviour_q;
            chan_a_sleep_pfm <= (pstate == PS_SLEEP) && chan_a_sleep_behaviour_q;
        end
    end

endmodule : b3cfg_regs
`default_nettype wire

// file: b3cfg_regs_properties.sv
/*
 Concurrent checks on the ports of the third buck configuration bank.
 Assumes one clock domain (mclk) and the synchronous active-low rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module b3cfg_regs_chk
    import b3cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic reg_addr_miss,
    // Configuration load and context
    input wire logic cfg_load,
    input wire logic single_phase,
    input wire logic [1:0] pwr_state,
    // Applied controls
    input wire logic [5:0] chan_a_level_out,
    input wire logic chan_a_range_out,
    input wire logic chan_a_level_upd,
    input wire logic [3:0] chan_a_switch_mode,
    input wire logic chan_a_sleep_off,
    input wire logic chan_a_sleep_pfm,
    input wire logic chan_a_current_limit_sel,
    input wire logic [1:0] chan_a_freq_sel,
    input wire logic [1:0] chan_a_phase_sel,
    input wire logic [1:0] chan_a_scaling_speed,
    input wire logic chan_b_range_out,
    input wire logic [5:0] chan_b_level_out,
    input wire logic chan_b_level_upd
);
    logic a_lvl, b_lvl, mapped;
    assign a_lvl = reg_addr inside {ADDR_CHA_NORMAL, ADDR_CHA_STANDBY, ADDR_CHA_SLEEP};
    assign b_lvl = reg_addr inside {ADDR_CHB_NORMAL, ADDR_CHB_STANDBY, ADDR_CHB_SLEEP};
    assign mapped = a_lvl || b_lvl || reg_addr == ADDR_CHA_MODE || reg_addr == ADDR_CHA_CONFIG;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read without valid");
    property p_no_valid; !reg_rd_en |=> !reg_rd_valid && !reg_addr_miss; endproperty
    a_no_valid: assert property (p_no_valid) else $error("valid without read");
    property p_miss; reg_rd_en && !mapped |=> reg_addr_miss && reg_rd_data == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped read not flagged as zero");
    property p_bit7; reg_rd_en && reg_addr != ADDR_CHA_CONFIG |=> !reg_rd_data[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("unused top bit reads one");
    property p_mode_rd; reg_rd_en && reg_addr == ADDR_CHA_MODE |=> reg_rd_data[7:6] == 2'h0 && !reg_rd_data[4]; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("unused mode bits read one");
    property p_range_a;
        reg_rd_en && a_lvl && !cfg_load && !$past(cfg_load) |=> reg_rd_data[6] == chan_a_range_out;
    endproperty
    a_range_a: assert property (p_range_a) else $error("channel A range readback differs");
    property p_range_b;
        reg_rd_en && b_lvl && !single_phase && !$past(single_phase) && !cfg_load && !$past(cfg_load)
            |=> reg_rd_data[6] == chan_b_range_out;
    endproperty
    a_range_b: assert property (p_range_b) else $error("channel B range readback differs");
    property p_cfg_out;
        reg_wr_en && reg_addr == ADDR_CHA_CONFIG ##1 !(reg_wr_en && reg_addr == ADDR_CHA_CONFIG) |=>
            {chan_a_scaling_speed, chan_a_phase_sel, chan_a_freq_sel} == $past(reg_wr_data[7:2], 2)
            && chan_a_current_limit_sel == $past(reg_wr_data[0], 2);
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("config outputs do not follow write");
    sequence s_mode_wr;
        reg_wr_en && reg_addr == ADDR_CHA_MODE ##1 !(reg_wr_en && reg_addr == ADDR_CHA_MODE);
    endsequence
    property p_mode_out; s_mode_wr |=> chan_a_switch_mode == $past(reg_wr_data[3:0], 2); endproperty
    a_mode_out: assert property (p_mode_out) else $error("switch mode does not follow write");
    property p_sleep; pwr_state == PS_CODE_SLEEP |=> chan_a_sleep_off != chan_a_sleep_pfm; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep behaviour flags wrong in sleep");
    property p_awake; pwr_state != PS_CODE_SLEEP |=> !chan_a_sleep_off && !chan_a_sleep_pfm; endproperty
    a_awake: assert property (p_awake) else $error("sleep flag set while awake");
    // Guarded by the past reset so the reset clear itself is not taken as a change
    property p_upd_a; $past(rst_n) && $changed(chan_a_level_out) |-> chan_a_level_upd; endproperty
    a_upd_a: assert property (p_upd_a) else $error("level change without update pulse");
    property p_upd_b; $past(rst_n) && $changed(chan_b_level_out) |-> chan_b_level_upd; endproperty
    a_upd_b: assert property (p_upd_b) else $error("channel B level change without update pulse");

    c_miss: cover property (reg_rd_en && !mapped);
    c_load: cover property (cfg_load);
    c_pfm: cover property (chan_a_sleep_pfm);
endmodule : b3cfg_regs_chk

bind b3cfg_regs b3cfg_regs_chk chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .reg_addr_miss(reg_addr_miss), .cfg_load(cfg_load), .single_phase(single_phase), .pwr_state(pwr_state),
    .chan_a_level_out(chan_a_level_out), .chan_a_range_out(chan_a_range_out), .chan_a_level_upd(chan_a_level_upd),
    .chan_a_switch_mode(chan_a_switch_mode), .chan_a_sleep_off(chan_a_sleep_off),
    .chan_a_sleep_pfm(chan_a_sleep_pfm), .chan_a_current_limit_sel(chan_a_current_limit_sel),
    .chan_a_freq_sel(chan_a_freq_sel), .chan_a_phase_sel(chan_a_phase_sel),
    .chan_a_scaling_speed(chan_a_scaling_speed), .chan_b_range_out(chan_b_range_out),
    .chan_b_level_out(chan_b_level_out), .chan_b_level_upd(chan_b_level_upd));
`default_nettype wire

// file: b3cfg_regs_tb.sv
/*
 Self-checking bench for the third buck configuration bank.
 Assumes the checker is bound in from its own file; drives all inputs itself.
*/
`timescale 1ns/1ps
`default_nettype none
module b3cfg_regs_tb
    import b3cfg_pkg::*;
;
    logic mclk, rst_n, reg_wr_en, reg_rd_en, cfg_load, cfg_range_a, cfg_range_b, single_phase;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [1:0] pwr_state, chan_a_freq_sel, chan_a_phase_sel, chan_a_scaling_speed;
    logic reg_rd_valid, reg_addr_miss, chan_a_range_out, chan_a_level_upd, chan_a_sleep_off, chan_a_sleep_pfm;
    logic chan_a_current_limit_sel, chan_b_range_out, chan_b_level_upd;
    logic [5:0] chan_a_level_out, chan_b_level_out;
    logic [3:0] chan_a_switch_mode;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] addr_t [8] = '{ADDR_CHA_NORMAL, ADDR_CHA_STANDBY, ADDR_CHA_SLEEP, ADDR_CHA_MODE,
        ADDR_CHA_CONFIG, ADDR_CHB_NORMAL, ADDR_CHB_STANDBY, ADDR_CHB_SLEEP};
    logic [7:0] mask_t [8] = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff, 8'h3f, 8'h3f, 8'h3f};
    logic [7:0] pat_t [3] = '{8'hff, 8'h95, 8'h6a};

    b3cfg_regs dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .reg_addr_miss(reg_addr_miss), .cfg_load(cfg_load), .cfg_range_a(cfg_range_a), .cfg_range_b(cfg_range_b),
        .pwr_state(pwr_state), .single_phase(single_phase), .chan_a_level_out(chan_a_level_out),
        .chan_a_range_out(chan_a_range_out), .chan_a_level_upd(chan_a_level_upd),
        .chan_a_switch_mode(chan_a_switch_mode), .chan_a_sleep_off(chan_a_sleep_off),
        .chan_a_sleep_pfm(chan_a_sleep_pfm), .chan_a_current_limit_sel(chan_a_current_limit_sel),
        .chan_a_freq_sel(chan_a_freq_sel), .chan_a_phase_sel(chan_a_phase_sel),
        .chan_a_scaling_speed(chan_a_scaling_speed), .chan_b_level_out(chan_b_level_out),
        .chan_b_range_out(chan_b_range_out), .chan_b_level_upd(chan_b_level_upd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Every task starts and ends 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Idle cycle after each strobe so no strobe is driven twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        step(1);
        reg_wr_en = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic miss);
        reg_addr = a;
        reg_rd_en = 1'b1;
        step(1);
        reg_rd_en = 1'b0;
        cmp({7'h0, reg_rd_valid}, 8'h01);
        cmp({7'h0, reg_addr_miss}, {7'h0, miss});
        cmp(reg_rd_data, exp);
        step(1);
    endtask : rd

    function automatic logic [7:0] img(input int i, input logic ra, input logic rb, input logic [7:0] v);
        img = (v & mask_t[i]) | (i < 3 ? {1'b0, ra, 6'h00} : (i > 4 ? {1'b0, rb, 6'h00} : 8'h00));
    endfunction : img

    initial begin
        #1000000;
        miscompares++;
        close_out();
    end

    initial begin
        logic [1:0] e;
        rst_n = 1'b0;
        {reg_wr_en, reg_rd_en, cfg_load, cfg_range_a, cfg_range_b, single_phase} = 6'h00;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
        pwr_state = PS_CODE_NORMAL;
        step(12);
        rst_n = 1'b1;
        step(1);
        for (int i = 0; i < 8; i++) rd(addr_t[i], 8'h00, 1'b0);
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 8; i++) begin
                wr(addr_t[i], pat_t[j]);
                rd(addr_t[i], img(i, 1'b0, 1'b0, pat_t[j]), 1'b0);
            end
            cmp({chan_a_scaling_speed, chan_a_phase_sel, chan_a_freq_sel, 1'b0, chan_a_current_limit_sel},
                pat_t[j] & 8'hfd);
            cmp({4'h0, chan_a_switch_mode}, pat_t[j] & 8'h0f);
        end
        wr(8'h46, 8'hff);
        rd(8'h46, 8'h00, 1'b1);
        rd(8'h41, 8'h00, 1'b1);
        for (int k = 0; k < 2; k++) begin
            cfg_range_a = ~k[0];
            cfg_range_b = k[0];
            cfg_load = 1'b1;
            step(1);
            cfg_load = 1'b0;
            step(1);
            for (int i = 0; i < 8; i++) rd(addr_t[i], img(i, ~k[0], k[0], 8'h6a), 1'b0);
            cmp({6'h00, chan_a_range_out, chan_b_range_out}, {6'h00, ~k[0], k[0]});
        end
        for (int i = 0; i < 8; i++) begin
            if (mask_t[i] == 8'h3f) wr(addr_t[i], 8'(i * 7 + 3));
        end
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_CHA_MODE, m ? 8'h25 : 8'h05);
            for (int s = 0; s < 2; s++) begin
                single_phase = s[0];
                for (int p = 0; p < 4; p++) begin
                    pwr_state = 2'(p);
                    e = (p == 1 || p == 2) ? 2'(p) : 2'h0;
                    step(3);
                    cmp({2'h0, chan_a_level_out}, 8'(e * 7 + 3));
                    cmp({2'h0, chan_b_level_out}, s ? 8'(e * 7 + 3) : 8'((5 + e) * 7 + 3));
                    cmp({7'h0, chan_b_range_out}, {7'h0, ~s[0]});
                    cmp({6'h00, chan_a_sleep_pfm, chan_a_sleep_off}, p == 2 ? (m ? 8'h02 : 8'h01) : 8'h00);
                end
            end
        end
        close_out();
    end
endmodule : b3cfg_regs_tb
`default_nettype wire
